// ### tmrcs_top.v
// timer control/status register with its 16-bit / split 8-bit counter
// Summary of operation
// - high overflow flag sets when upper count byte rolls over from FF to its reload value
// - in 16-bit mode high flag sets when full count wraps from FFFF to the reload value
// - set high flag raises timer interrupt request while timer interrupt enabled
// - hardware never clears overflow flags; only software writing zero clears them
// - low overflow flag sets on every low byte rollover, any mode
// - low flag requests interrupt when low irq enable and timer interrupt enabled
// - capture mode enable bit one puts timer in capture mode
// - split select one: two independent 8-bit auto-reload counters
// - split select zero: single 16-bit auto-reload counter
// - run bit starts timer; in split mode gates only upper byte
// - clock select picks external clock and capture trigger source
// - capture event copies count into reload registers and sets high flag
// - 16-bit rollover loads reload value into counting registers
`timescale 1ns/1ps
`default_nettype none
`include "tmrcs_defines.vh"

module tmrcs_top #(
   parameter SYSTEM_CLOCK_DIV = `TMRCS_SYSTEM_CLOCK_DIV,
   parameter OSC_DIV = `TMRCS_OSC_DIV
) (
   input wire mclk,
   input wire resetn,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   input wire timer_irq_enable,
   input wire high_use_system_clock,
   input wire low_use_system_clock,
   input wire ext_osc_pin,
   input wire comparator_pin,
   output reg timer_irq_request,
   output reg high_overflow_pulse,
   output reg low_overflow_pulse
);

   reg [7:0] timer_control_status;
   reg [7:0] count_low_byte;
   reg [7:0] count_high_byte;
   reg [7:0] reload_low_byte;
   reg [7:0] reload_high_byte;
   reg [3:0] div12_count;
   reg [2:0] osc_edge_count;
   reg osc_prev;
   reg cmp_prev;
   wire osc_level;
   wire cmp_level;

   wire high_overflow_flag = timer_control_status[`TMRCS_BIT_HIGH_FLAG];
   wire low_overflow_flag = timer_control_status[`TMRCS_BIT_LOW_FLAG];
   wire low_overflow_irq_enable = timer_control_status[`TMRCS_BIT_LOW_IRQ_EN];
   wire capture_mode_enable = timer_control_status[`TMRCS_BIT_CAPTURE];
   wire split_mode_select = timer_control_status[`TMRCS_BIT_SPLIT];
   wire run_control = timer_control_status[`TMRCS_BIT_RUN];
   wire [1:0] external_clock_select =
      timer_control_status[`TMRCS_XCLK_MSB:`TMRCS_XCLK_LSB];

   // pins come from outside the clock domain
   tmrcs_sync osc_sync (
      .mclk(mclk),
      .resetn(resetn),
      .pin(ext_osc_pin),
      .level(osc_level)
   );

   tmrcs_sync cmp_sync (
      .mclk(mclk),
      .resetn(resetn),
      .pin(comparator_pin),
      .level(cmp_level)
   );

   // tick sources: system clock / 12, oscillator / 8, comparator rising edge
   wire div12_tick = (div12_count == SYSTEM_CLOCK_DIV[3:0] - 4'h1);
   wire osc_rise = osc_level & ~osc_prev;
   wire osc8_tick = osc_rise & (osc_edge_count == OSC_DIV[2:0] - 3'h1);
   wire cmp_rise = cmp_level & ~cmp_prev;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div12_count <= 4'h0;
         osc_edge_count <= 3'h0;
         osc_prev <= 1'b0;
         cmp_prev <= 1'b0;
      end else begin
         osc_prev <= osc_level;
         cmp_prev <= cmp_level;
         if (div12_tick) begin
            div12_count <= 4'h0;
         end else begin
            div12_count <= div12_count + 4'h1;
         end
         if (osc_rise) begin
            osc_edge_count <= osc8_tick ? 3'h0 : osc_edge_count + 3'h1;
         end
      end
   end

   reg ext_tick;
   reg capture_trigger;

   // 10 is treated like 00 for both clock and trigger
   always @* begin
      ext_tick = div12_tick;
      capture_trigger = cmp_rise;
      if (external_clock_select == `TMRCS_XCLK_OSC8) begin
         ext_tick = osc8_tick;
         capture_trigger = osc8_tick;
      end else if (external_clock_select == `TMRCS_XCLK_CMP) begin
         ext_tick = cmp_rise;
         capture_trigger = osc8_tick;
      end
   end

   wire low_tick = low_use_system_clock | ext_tick;
   wire high_tick = high_use_system_clock | ext_tick;

   // split: low always runs, high gated by run; 16-bit: both gated by run
   wire low_inc = split_mode_select ? low_tick : (run_control & low_tick);
   wire high_inc = split_mode_select ? (run_control & high_tick)
                                     : (low_inc & (count_low_byte == `TMRCS_BYTE_MAX));
   wire low_roll = low_inc & (count_low_byte == `TMRCS_BYTE_MAX);
   wire high_roll = high_inc & (count_high_byte == `TMRCS_BYTE_MAX);
   wire capture_event = capture_mode_enable & capture_trigger;

   wire wr_ctrl = sfr_wr & (sfr_addr == `TMRCS_ADDR_CTRL);
   wire wr_rll = sfr_wr & (sfr_addr == `TMRCS_ADDR_RELOAD_LOW);
   wire wr_rlh = sfr_wr & (sfr_addr == `TMRCS_ADDR_RELOAD_HIGH);
   wire wr_cl = sfr_wr & (sfr_addr == `TMRCS_ADDR_COUNT_LOW);
   wire wr_ch = sfr_wr & (sfr_addr == `TMRCS_ADDR_COUNT_HIGH);

   wire set_high = high_roll | capture_event;
   wire set_low = low_roll;

   reg [7:0] next_control;

   always @* begin
      next_control = timer_control_status;
      if (wr_ctrl) begin
         next_control = sfr_wdata;
      end
      // only software can clear a flag; a same-cycle set overrides it
      if (set_high) begin
         next_control[`TMRCS_BIT_HIGH_FLAG] = 1'b1;
      end
      if (set_low) begin
         next_control[`TMRCS_BIT_LOW_FLAG] = 1'b1;
      end
   end

   reg [7:0] next_low;
   reg [7:0] next_high;

   // in 16-bit mode the low byte reloads only with the full wrap
   always @* begin
      next_low = count_low_byte;
      next_high = count_high_byte;
      if (split_mode_select) begin
         if (low_roll) begin
            next_low = reload_low_byte;
         end else if (low_inc) begin
            next_low = count_low_byte + 8'h01;
         end
         if (high_roll) begin
            next_high = reload_high_byte;
         end else if (high_inc) begin
            next_high = count_high_byte + 8'h01;
         end
      end else if (high_roll) begin
         next_low = reload_low_byte;
         next_high = reload_high_byte;
      end else if (low_inc) begin
         next_low = count_low_byte + 8'h01;
         if (high_inc) begin
            next_high = count_high_byte + 8'h01;
         end
      end
      // a software write to a count byte takes priority over counting
      if (wr_cl) begin
         next_low = sfr_wdata;
      end
      if (wr_ch) begin
         next_high = sfr_wdata;
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         timer_control_status <= `TMRCS_CTRL_RESET;
         count_low_byte <= `TMRCS_BYTE_RESET;
         count_high_byte <= `TMRCS_BYTE_RESET;
         reload_low_byte <= `TMRCS_BYTE_RESET;
         reload_high_byte <= `TMRCS_BYTE_RESET;
      end else begin
         timer_control_status <= next_control;
         count_low_byte <= next_low;
         count_high_byte <= next_high;
         // capture snapshot is the count before this cycle's increment
         if (capture_event) begin
            reload_low_byte <= count_low_byte;
            reload_high_byte <= count_high_byte;
         end else begin
            if (wr_rll) begin
               reload_low_byte <= sfr_wdata;
            end
            if (wr_rlh) begin
               reload_high_byte <= sfr_wdata;
            end
         end
      end
   end

   reg [7:0] read_mux;

   always @* begin
      if (sfr_addr == `TMRCS_ADDR_CTRL) begin
         read_mux = timer_control_status;
      end else if (sfr_addr == `TMRCS_ADDR_RELOAD_LOW) begin
         read_mux = reload_low_byte;
      end else if (sfr_addr == `TMRCS_ADDR_RELOAD_HIGH) begin
         read_mux = reload_high_byte;
      end else if (sfr_addr == `TMRCS_ADDR_COUNT_LOW) begin
         read_mux = count_low_byte;
      end else if (sfr_addr == `TMRCS_ADDR_COUNT_HIGH) begin
         read_mux = count_high_byte;
      end else begin
         read_mux = 8'h00;
      end
   end

   // request follows the enabled flags one cycle late, held until they are cleared or timer_irq_enable drops
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata <= 8'h00;
         timer_irq_request <= 1'b0;
         high_overflow_pulse <= 1'b0;
         low_overflow_pulse <= 1'b0;
      end else begin
         sfr_rdata <= sfr_rd ? read_mux : 8'h00;
         timer_irq_request <= timer_irq_enable &
            (high_overflow_flag | (low_overflow_flag & low_overflow_irq_enable));
         high_overflow_pulse <= set_high;
         low_overflow_pulse <= set_low;
      end
   end

endmodule // tmrcs_top

`default_nettype wire

// ### tmrcs_defines.vh
// constants for the timer control/status block and its counter
`ifndef TMRCS_DEFINES_VH
`define TMRCS_DEFINES_VH

// special-function register addresses
`define TMRCS_ADDR_CTRL 8'h91
`define TMRCS_ADDR_RELOAD_LOW 8'h92
`define TMRCS_ADDR_RELOAD_HIGH 8'h93
`define TMRCS_ADDR_COUNT_LOW 8'h94
`define TMRCS_ADDR_COUNT_HIGH 8'h95

// control/status field positions
`define TMRCS_BIT_HIGH_FLAG 7
`define TMRCS_BIT_LOW_FLAG 6
`define TMRCS_BIT_LOW_IRQ_EN 5
`define TMRCS_BIT_CAPTURE 4
`define TMRCS_BIT_SPLIT 3
`define TMRCS_BIT_RUN 2
`define TMRCS_XCLK_MSB 1
`define TMRCS_XCLK_LSB 0

// reset values and the byte maximum
`define TMRCS_CTRL_RESET 8'h00
`define TMRCS_BYTE_RESET 8'h00
`define TMRCS_BYTE_MAX 8'hFF

// external clock select codes
`define TMRCS_XCLK_DIV12 2'h0
`define TMRCS_XCLK_OSC8 2'h1
`define TMRCS_XCLK_DIV12_ALT 2'h2
`define TMRCS_XCLK_CMP 2'h3

// divider ratios
`define TMRCS_SYSTEM_CLOCK_DIV 12
`define TMRCS_OSC_DIV 8

`endif

// ### tmrcs_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module tmrcs_sync (
   input wire mclk,
   input wire resetn,
   input wire pin,
   output reg level
);

   reg stage1;
   reg stage2;
   reg stage3;

   // stage1 feeds only stage2; the filter looks at stages 2 and 3
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level <= 1'b0;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            level <= stage3;
         end
      end
   end

endmodule // tmrcs_sync

`default_nettype wire

// ### tmrcs_cpu.sv
// processor-side model that issues special-function register cycles
`timescale 1ns/1ps
`default_nettype none
module tmrcs_cpu (
   input wire logic mclk,
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic sfr_rd,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata
);
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   end
   // a strobe stays up until the next call, so back-to-back cycles need no gap
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_rd = 1'b0;
      sfr_wr = 1'b1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      sfr_addr = a;
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
      @(posedge mclk);
      #1;
      d = sfr_rdata;
   endtask
   task automatic idle();
      @(negedge mclk);
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   endtask
endmodule // tmrcs_cpu
`default_nettype wire

// ### tmrcs_props.sv
// concurrent checks on the timer control/status ports
`timescale 1ns/1ps
`default_nettype none
module tmrcs_props (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic timer_irq_request,
   input wire logic high_overflow_pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   wire ctrl_wr = sfr_wr && sfr_addr == 8'h91;
   // run only changes by software, so a mirror of the written bit is exact
   logic ctrl_run;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_run <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl_run <= sfr_wdata[2];
      end
   end
   sequence s_wr(a); sfr_wr && sfr_addr == a; endsequence
   // a running counter may step between the write and the read
   sequence s_wr_stopped(a); !ctrl_run && sfr_wr && sfr_addr == a; endsequence
   sequence s_rd(a); sfr_rd && sfr_addr == a; endsequence
   chk_rdata_idle: assert property (sfr_rdata != 8'h00 |-> $past(sfr_rd))
      else $error("read data without a read");
   chk_rd_unmapped: assert property ($past(sfr_rd) && ($past(sfr_addr) < 8'h91
      || $past(sfr_addr) > 8'h95) |-> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_ctrl_readback: assert property (s_wr(8'h91) ##1 s_rd(8'h91) |=>
      (sfr_rdata & 8'h3F) == ($past(sfr_wdata, 2) & 8'h3F))
      else $error("control field lost");
   chk_count_readback: assert property (s_wr_stopped(8'h95) ##1 s_rd(8'h95) |=>
      sfr_rdata == $past(sfr_wdata, 2))
      else $error("count write lost");
   chk_irq_needs_en: assert property (timer_irq_request |-> $past(timer_irq_enable))
      else $error("request while disabled");
   chk_irq_on_high: assert property (
      high_overflow_pulse && timer_irq_enable |=> timer_irq_request)
      else $error("high overflow gave no request");
   chk_irq_hold: assert property (
      timer_irq_request && timer_irq_enable && !$past(ctrl_wr) |=> timer_irq_request)
      else $error("request dropped without a write");
   chk_flag_sticky: assert property (
      sfr_rd && sfr_addr == 8'h91 && high_overflow_pulse && !$past(ctrl_wr) |=> sfr_rdata[7])
      else $error("high flag not seen after overflow");
endmodule // tmrcs_props
bind tmrcs_top tmrcs_props u_props (.mclk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd,
   .sfr_wdata, .sfr_rdata, .timer_irq_enable, .timer_irq_request, .high_overflow_pulse);
`default_nettype wire

// ### tmrcs_top_tb.sv
// self-checking bench for the timer control/status block
`timescale 1ns/1ps
`default_nettype none
module tmrcs_top_tb;
   logic mclk, resetn, sfr_wr, sfr_rd, timer_irq_enable, high_use_system_clock;
   logic low_use_system_clock, ext_osc_pin, comparator_pin;
   logic timer_irq_request, high_overflow_pulse, low_overflow_pulse;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, e;
   int fails = 0, check_count = 0, seed = 77749, i;
   tmrcs_top u_dut (.mclk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .timer_irq_enable, .high_use_system_clock, .low_use_system_clock, .ext_osc_pin,
      .comparator_pin, .timer_irq_request, .high_overflow_pulse, .low_overflow_pulse);
   tmrcs_cpu u_cpu (.mclk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [7:0] exp_ctrl(input logic [7:0] w, input logic h, input logic l);
      return {w[7] | h, w[6] | l, w[5:0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_lvl(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      u_cpu.rd(a, d);
      chk(d, exp);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // the whole run needs well under 1000 cycles
   initial begin
      #100000;
      fails++;
      end_sim();
   end
   initial begin
      resetn = 1'b0;
      timer_irq_enable = 1'b0;
      high_use_system_clock = 1'b0;
      low_use_system_clock = 1'b0;
      ext_osc_pin = 1'b0;
      comparator_pin = 1'b0;
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      u_cpu.wr(8'h96, 8'hFF);
      for (i = 'h90; i <= 'h96; i++) rchk(i[7:0], 8'h00);
      $display("reset and unmapped test done");
      // run stays clear and pins idle, so nothing counts far enough to set a flag
      for (i = 0; i < 16; i++) begin
         e = 8'($random(seed));
         e = {e[7:2], i[1:0]} & 8'hFB;
         u_cpu.wr(8'h91, e);
         rchk(8'h91, e);
      end
      $display("control field test done");
      u_cpu.wr(8'h91, 8'h00);
      timer_irq_enable = 1'b1;
      low_use_system_clock = 1'b1;
      u_cpu.wr(8'h93, 8'h12);
      u_cpu.wr(8'h92, 8'h34);
      u_cpu.wr(8'h95, 8'hFF);
      u_cpu.wr(8'h94, 8'hFF);
      u_cpu.wr(8'h91, 8'h04);
      for (i = 0; i < 4; i++) u_cpu.rd(8'h91, d);
      chk(d, exp_ctrl(8'h04, 1'b1, 1'b1));
      chk_lvl(timer_irq_request, 1'b1);
      rchk(8'h95, 8'h12);
      u_cpu.idle();
      timer_irq_enable = 1'b0;
      repeat (20) @(negedge mclk);
      rchk(8'h91, exp_ctrl(8'h04, 1'b1, 1'b1));
      chk_lvl(timer_irq_request, 1'b0);
      u_cpu.wr(8'h91, 8'h04);
      timer_irq_enable = 1'b1;
      rchk(8'h91, 8'h04);
      $display("wrap and flag test done");
      u_cpu.wr(8'h91, 8'h08);
      high_use_system_clock = 1'b1;
      u_cpu.wr(8'h94, 8'hFF);
      u_cpu.wr(8'h91, 8'h08);
      @(posedge mclk);
      #1;
      chk_lvl(low_overflow_pulse, 1'b1);
      rchk(8'h91, exp_ctrl(8'h08, 1'b0, 1'b1));
      // high byte has a tick every cycle but run is clear
      rchk(8'h95, 8'h12);
      $display("split and clear race test done");
      u_cpu.wr(8'h91, 8'h00);
      u_cpu.wr(8'h94, 8'h00);
      u_cpu.wr(8'h95, 8'h00);
      rchk(8'h95, 8'h00);
      u_cpu.wr(8'h91, 8'h14);
      u_cpu.idle();
      comparator_pin = 1'b1;
      repeat (12) @(negedge mclk);
      rchk(8'h91, exp_ctrl(8'h14, 1'b1, 1'b0));
      rchk(8'h93, 8'h00);
      u_cpu.rd(8'h92, d);
      // pin to capture takes five edges, so the snapshot holds the fourth step
      chk(d, 8'h04);
      u_cpu.idle();
      $display("capture test done");
      u_cpu.wr(8'h91, 8'h00);
      u_cpu.rd(8'h94, e);
      u_cpu.wr(8'h91, 8'h11);
      u_cpu.idle();
      // eight oscillator periods, each half long enough to pass the filter
      for (i = 0; i < 16; i++) begin
         ext_osc_pin = ~ext_osc_pin;
         repeat (4) @(negedge mclk);
      end
      rchk(8'h91, exp_ctrl(8'h11, 1'b1, 1'b0));
      rchk(8'h92, e);
      $display("oscillator capture test done");
      end_sim();
   end
endmodule // tmrcs_top_tb
`default_nettype wire
